//--- include/lmc_pkg.sv
package lmc_pkg;

  // ********************************************************
  // Keystroke codes
  // ********************************************************
  localparam logic [7:0] KEY_CR = 8'h0d;
  localparam logic [7:0] KEY_SLASH = 8'h2f;
  localparam logic [7:0] KEY_UP = 8'h5e;
  localparam logic [7:0] KEY_DEL = 8'h7f;
  localparam logic [7:0] KEY_D0 = 8'h30;
  localparam logic [7:0] KEY_D7 = 8'h37;
  localparam logic [7:0] KEY_B = 8'h42;
  localparam logic [7:0] KEY_D = 8'h44;
  localparam logic [7:0] KEY_G = 8'h47;
  localparam logic [7:0] KEY_L = 8'h4c;
  localparam logic [7:0] KEY_O = 8'h4f;
  localparam logic [7:0] KEY_Q = 8'h51;
  localparam logic [7:0] KEY_S = 8'h53;
  localparam logic [7:0] KEY_T = 8'h54;
  localparam logic [7:0] KEY_U = 8'h55;
  localparam logic [7:0] KEY_Y = 8'h59;

  // Function key numbers and host code used in emulation
  localparam logic [7:0] FKEY_CLEAR = 8'h00;
  localparam logic [7:0] FKEY_DUPLEX = 8'h01;
  localparam logic [7:0] FKEY_SYSTEM = 8'h0d;
  localparam logic [7:0] HOST_TO_SYSTEM = 8'h1d;

  // ********************************************************
  // Entry, address and bank figures
  // ********************************************************
  localparam int ENTRY_DIGITS = 6;
  localparam int ENTRY_W = 3 * ENTRY_DIGITS;
  localparam logic [2:0] ENTRY_CNT_MAX = 3'h6;
  localparam logic [15:0] ADDR_STEP = 16'h0002;
  localparam logic [2:0] BANK_LAST_MAPPED = 3'h3;
  localparam logic [2:0] BANK_MAX = 3'h4;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam int ROM_BIT = 15;
  localparam logic TTY_FULL_RST = 1'b1;

  // Valid option numbers: 1..3777 and 4001..7777 octal
  localparam logic [11:0] OPT_LO1 = 12'h001;
  localparam logic [11:0] OPT_HI1 = 12'h7ff;
  localparam logic [11:0] OPT_LO2 = 12'h801;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [3:0] {
    ST_PATTERN, ST_MONITOR, ST_EXAM, ST_WRITE, ST_READ, ST_WAIT_CR,
    ST_OPTS, ST_REFRESH, ST_TTY, ST_SYSTEM, ST_RUN
  } lmc_state_t;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_REFRESH, CMD_GO, CMD_LOAD, CMD_UNLOAD, CMD_OPTS,
    CMD_TTY, CMD_PATTERN
  } lmc_cmd_t;

  typedef enum logic [2:0] {
    DISP_PATTERN, DISP_PROMPT, DISP_WORD, DISP_ENTRY, DISP_QADDR
  } lmc_disp_t;

endpackage

//--- hdl/lmc_octal_entry.sv
`timescale 1ns/100ps
// Octal digit accumulator; one digit pushed or popped per cycle
module lmc_octal_entry
  import lmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic push,
  input wire logic pop,
  input wire logic clear,
  input wire logic [2:0] digit,
  output logic [ENTRY_W-1:0] value,
  output logic [2:0] count
);

  // ********************************************************
  // Digit stack
  // ********************************************************
  // Digits shift in from the right, so a pop is a plain shift back
  always_ff @(posedge clock) begin
    if (srst || clear) begin
      value <= '0;
      count <= 3'h0;
    end else if (push && count != ENTRY_CNT_MAX) begin
      value <= {value[ENTRY_W-4:0], digit};
      count <= count + 3'h1;
    end else if (pop && count != 3'h0) begin
      value <= {3'h0, value[ENTRY_W-1:3]};
      count <= count - 3'h1;
    end
  end

endmodule

//--- hdl/lmc_monitor.sv
`timescale 1ns/100ps
module lmc_monitor
  import lmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic key_valid,
  input wire logic key_func,
  input wire logic [7:0] key_code,
  input wire logic host_valid,
  input wire logic [7:0] host_code,
  input wire logic local_init,
  input wire logic halt_exec,
  input wire logic [15:0] halt_pc,
  input wire logic opts_end,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [17:0] mem_addr,
  output logic mem_rom_sel,
  output logic [15:0] mem_wdata,
  output logic disp_stb,
  output lmc_disp_t disp_kind,
  output logic [2:0] disp_bank,
  output logic [15:0] disp_addr,
  output logic [17:0] disp_data,
  output logic refresh_start,
  output logic [17:0] refresh_addr,
  output logic refresh_rom_sel,
  output logic go_start,
  output logic [15:0] go_addr,
  output logic tape_load,
  output logic opt_load,
  output logic [11:0] opt_num,
  output logic opt_unload,
  output logic opt_status,
  output logic tty_active,
  output logic tty_clear,
  output logic tty_full,
  output logic system_mode,
  output logic system_enter
);

  // ********************************************************
  // Declarations
  // ********************************************************
  lmc_state_t state_q;
  lmc_cmd_t cmd_q;
  lmc_cmd_t key_cmd;
  logic bsel_q;
  logic [2:0] bank_q;
  logic [15:0] cur_addr_q;
  logic rd_after_q;
  logic [15:0] halt_q;
  logic echo_q;
  logic loc_s1_q;
  logic loc_s2_q;
  logic loc_s3_q;
  logic loc_edge;
  logic [ENTRY_W-1:0] acc_val;
  logic [2:0] acc_cnt;
  logic has_dig;
  logic opt_ok;
  logic is_dig, is_cr, is_step, is_up, is_del, is_b, is_q, is_s;
  logic acc_push, acc_pop, acc_clr;
  logic ev_prompt, ev_mem_rd, ev_mem_wr, ev_word, ev_q, ev_sys;
  logic ex_refresh, ex_go, ex_tape, ex_opt, ex_unload, ex_opts;
  logic ex_tty, ex_pattern, ev_opt_next;
  logic [15:0] mem_va;
  logic [15:0] step_va;
  logic [18:0] mem_map;
  logic [18:0] ref_map;

  // Bank map: {rom_select, physical address}
  function automatic logic [18:0] phys_of(input logic [2:0] b, input logic [15:0] va);
    logic [18:0] r;
    r = {3'h0, va};
    if (b == BANK_RST) begin
      r[18] = va[ROM_BIT];
    end else if (b <= BANK_LAST_MAPPED) begin
      r[17:16] = b[1:0];
    end
    return r;
  endfunction

  // ********************************************************
  // Pushbutton synchroniser
  // ********************************************************
  // Third stage only feeds the edge detect, never the first
  always_ff @(posedge clock) begin
    if (srst) begin
      loc_s1_q <= 1'b0;
      loc_s2_q <= 1'b0;
      loc_s3_q <= 1'b0;
    end else begin
      loc_s1_q <= local_init;
      loc_s2_q <= loc_s1_q;
      loc_s3_q <= loc_s2_q;
    end
  end

  assign loc_edge = loc_s2_q & ~loc_s3_q;

  // ********************************************************
  // Keystroke decode
  // ********************************************************
  assign is_dig = key_valid && !key_func && key_code >= KEY_D0 && key_code <= KEY_D7;
  assign is_cr = key_valid && !key_func && key_code == KEY_CR;
  assign is_up = key_valid && !key_func && key_code == KEY_UP;
  assign is_step = is_up || (key_valid && !key_func && key_code == KEY_SLASH);
  assign is_del = key_valid && !key_func && key_code == KEY_DEL;
  assign is_b = key_valid && !key_func && key_code == KEY_B;
  assign is_q = key_valid && !key_func && key_code == KEY_Q;
  assign is_s = key_valid && !key_func && key_code == KEY_S;
  assign has_dig = acc_cnt != 3'h0;
  assign step_va = is_up ? cur_addr_q - ADDR_STEP : cur_addr_q + ADDR_STEP;
  assign opt_ok = acc_val[ENTRY_W-1:12] == '0 &&
                  ((acc_val[11:0] >= OPT_LO1 && acc_val[11:0] <= OPT_HI1) ||
                   acc_val[11:0] >= OPT_LO2);

  // Letter keys that wait for carriage return
  always_comb begin
    key_cmd = CMD_NONE;
    if (key_valid && !key_func) begin
      unique case (key_code)
        KEY_D: key_cmd = CMD_REFRESH;
        KEY_G: key_cmd = CMD_GO;
        KEY_L: key_cmd = CMD_LOAD;
        KEY_U: key_cmd = CMD_UNLOAD;
        KEY_O: key_cmd = CMD_OPTS;
        KEY_Y: key_cmd = CMD_TTY;
        KEY_T: key_cmd = CMD_PATTERN;
        default: key_cmd = CMD_NONE;
      endcase
    end
  end

  // ********************************************************
  // Event decode per state
  // ********************************************************
  always_comb begin
    acc_push = 1'b0;
    acc_pop = 1'b0;
    acc_clr = 1'b0;
    ev_prompt = 1'b0;
    ev_mem_rd = 1'b0;
    ev_mem_wr = 1'b0;
    ev_word = 1'b0;
    ev_q = 1'b0;
    ev_sys = 1'b0;
    ev_opt_next = 1'b0;
    ex_refresh = 1'b0;
    ex_go = 1'b0;
    ex_tape = 1'b0;
    ex_opt = 1'b0;
    ex_unload = 1'b0;
    ex_opts = 1'b0;
    ex_tty = 1'b0;
    ex_pattern = 1'b0;
    mem_va = cur_addr_q;
    if (!loc_edge) begin
      unique case (state_q)
        ST_PATTERN: ev_prompt = is_cr;
        ST_MONITOR: begin
          if (bsel_q) begin
            acc_clr = 1'b0;
          end else if (is_dig && cmd_q == CMD_NONE) begin
            acc_push = 1'b1;
          end else if (is_del && cmd_q == CMD_NONE) begin
            acc_pop = 1'b1;
          end else if (is_step && !is_up && has_dig && cmd_q == CMD_NONE) begin
            ev_mem_rd = 1'b1;
            mem_va = acc_val[15:0];
            acc_clr = 1'b1;
          end else if (is_q) begin
            ev_q = 1'b1;
            acc_clr = 1'b1;
          end else if (is_s) begin
            ev_sys = 1'b1;
            acc_clr = 1'b1;
          end else if (is_cr) begin
            acc_clr = 1'b1;
            unique case (cmd_q)
              CMD_NONE: ev_prompt = !has_dig;
              CMD_REFRESH: ex_refresh = has_dig;
              CMD_GO: ex_go = has_dig;
              CMD_LOAD: begin
                ex_tape = !has_dig;
                ex_opt = has_dig && opt_ok;
                ev_prompt = !has_dig || opt_ok;
              end
              CMD_UNLOAD: begin
                ex_unload = !has_dig;
                ev_prompt = !has_dig;
              end
              CMD_OPTS: ex_opts = !has_dig;
              CMD_TTY: ex_tty = !has_dig;
              CMD_PATTERN: ex_pattern = !has_dig;
            endcase
          end
        end
        ST_EXAM: begin
          if (is_dig) begin
            acc_push = 1'b1;
          end else if (is_del) begin
            acc_pop = 1'b1;
          end else if (is_step || is_cr) begin
            acc_clr = 1'b1;
            ev_mem_wr = has_dig;
            ev_prompt = is_cr && !has_dig;
            ev_mem_rd = is_step && !has_dig;
            mem_va = has_dig ? cur_addr_q : step_va;  // Deposit lands on shown word
          end
        end
        ST_WRITE: begin
          // Follow-up read waits until the write's request has dropped
          ev_mem_rd = rd_after_q && !mem_req;
          ev_prompt = mem_ack && !rd_after_q;
        end
        ST_READ: ev_word = mem_ack;
        ST_WAIT_CR, ST_REFRESH: ev_prompt = is_cr;
        ST_OPTS: begin
          ev_prompt = is_cr && opts_end;
          ev_opt_next = is_cr && !opts_end;
        end
        ST_TTY: begin
          ev_sys = (key_valid && key_func && key_code == FKEY_SYSTEM) ||
                   (host_valid && host_code == HOST_TO_SYSTEM);
        end
        ST_SYSTEM, ST_RUN: ev_sys = 1'b0;
      endcase
    end
  end

  assign mem_map = phys_of(bank_q, mem_va);
  assign ref_map = phys_of(bank_q, acc_val[15:0]);

  lmc_octal_entry u_entry (
    .clock(clock),
    .srst(srst),
    .push(acc_push),
    .pop(acc_pop),
    .clear(acc_clr || loc_edge),
    .digit(key_code[2:0]),
    .value(acc_val),
    .count(acc_cnt)
  );

  // ********************************************************
  // Command state
  // ********************************************************
  // Keys not matched above leave every field alone
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_PATTERN;
      cmd_q <= CMD_NONE;
      bsel_q <= 1'b0;
      bank_q <= BANK_RST;
      cur_addr_q <= '0;
      rd_after_q <= 1'b0;
    end else if (loc_edge) begin
      state_q <= ST_PATTERN;
      cmd_q <= CMD_NONE;
      bsel_q <= 1'b0;
    end else begin
      if (ev_prompt) state_q <= ST_MONITOR;
      if (ev_word) state_q <= ST_EXAM;
      if (ev_q) state_q <= ST_WAIT_CR;
      if (ex_refresh) state_q <= ST_REFRESH;
      if (ex_go) state_q <= ST_RUN;
      if (ex_opts) state_q <= ST_OPTS;
      if (ex_tty) state_q <= ST_TTY;
      if (ex_pattern) state_q <= ST_PATTERN;
      if (ev_sys) state_q <= ST_SYSTEM;
      if (ev_mem_rd) begin
        state_q <= ST_READ;
        cur_addr_q <= mem_va;
      end
      if (ev_mem_wr) begin
        state_q <= ST_WRITE;
        rd_after_q <= is_step;
        if (is_step) cur_addr_q <= step_va;
      end
      if (state_q == ST_MONITOR) begin
        if (bsel_q) begin
          if (is_dig || is_del || is_cr) bsel_q <= 1'b0;
          if (is_dig && key_code[2:0] <= BANK_MAX) bank_q <= key_code[2:0];
        end else if (is_b && cmd_q == CMD_NONE && !has_dig) begin
          bsel_q <= 1'b1;
        end else if (is_cr || is_q || is_s) begin
          cmd_q <= CMD_NONE;
        end else if (is_del && cmd_q != CMD_NONE) begin
          cmd_q <= CMD_NONE;
        end else if (key_cmd != CMD_NONE && cmd_q == CMD_NONE) begin
          cmd_q <= key_cmd;
        end
      end
    end
  end

  // ********************************************************
  // Memory access
  // ********************************************************
  // Request holds until acknowledged; keys arriving meanwhile are ignored
  always_ff @(posedge clock) begin
    if (srst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_rom_sel <= 1'b0;
      mem_wdata <= '0;
    end else if (ev_mem_wr) begin
      mem_req <= 1'b1;
      mem_we <= 1'b1;
      mem_addr <= mem_map[17:0];
      mem_rom_sel <= mem_map[18];
      mem_wdata <= acc_val[15:0];
    end else if (ev_mem_rd) begin
      mem_req <= 1'b1;
      mem_we <= 1'b0;
      mem_addr <= mem_map[17:0];
      mem_rom_sel <= mem_map[18];
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // ********************************************************
  // Saved halt address
  // ********************************************************
  // A halt in the same cycle as Q wins: the fresh value matters
  always_ff @(posedge clock) begin
    if (srst) begin
      halt_q <= '0;
    end else if (halt_exec) begin
      halt_q <= halt_pc;
    end else if (ev_q) begin
      halt_q <= halt_q - ADDR_STEP;
    end
  end

  // ********************************************************
  // Display requests
  // ********************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      echo_q <= 1'b0;
      disp_stb <= 1'b0;
      disp_kind <= DISP_PATTERN;
      disp_bank <= BANK_RST;
      disp_addr <= '0;
      disp_data <= '0;
    end else begin
      echo_q <= state_q == ST_EXAM && (acc_push || acc_pop);
      disp_stb <= 1'b0;
      disp_bank <= bank_q;
      if (loc_edge || ex_pattern) begin
        disp_stb <= 1'b1;
        disp_kind <= DISP_PATTERN;
      end else if (ev_prompt) begin
        disp_stb <= 1'b1;
        disp_kind <= DISP_PROMPT;
      end else if (ev_word) begin
        disp_stb <= 1'b1;
        disp_kind <= DISP_WORD;
        disp_addr <= cur_addr_q;
        disp_data <= {2'h0, mem_rdata};
      end else if (ev_q) begin
        disp_stb <= 1'b1;
        disp_kind <= DISP_QADDR;
        disp_data <= {2'h0, halt_q - ADDR_STEP};
      end else if (echo_q) begin
        disp_stb <= 1'b1;
        disp_kind <= DISP_ENTRY;
        disp_data <= acc_val;
      end
    end
  end

  // ********************************************************
  // Command outputs
  // ********************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      refresh_start <= 1'b0;
      refresh_addr <= '0;
      refresh_rom_sel <= 1'b0;
      go_start <= 1'b0;
      go_addr <= '0;
      tape_load <= 1'b0;
      opt_load <= 1'b0;
      opt_num <= '0;
      opt_unload <= 1'b0;
      opt_status <= 1'b0;
      system_enter <= 1'b0;
    end else begin
      refresh_start <= ex_refresh;
      go_start <= ex_go;
      tape_load <= ex_tape;
      opt_load <= ex_opt;
      opt_unload <= ex_unload;
      opt_status <= ex_opts || ev_opt_next;
      system_enter <= ev_sys;
      if (ex_refresh) begin
        refresh_addr <= ref_map[17:0];
        refresh_rom_sel <= ref_map[18];
      end
      if (ex_go) go_addr <= acc_val[15:0];
      if (ex_opt) opt_num <= acc_val[11:0];
    end
  end

  // ********************************************************
  // Mode levels and emulation keys
  // ********************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      tty_active <= 1'b0;
      tty_clear <= 1'b0;
      tty_full <= TTY_FULL_RST;
      system_mode <= 1'b0;
    end else begin
      tty_clear <= 1'b0;
      if (loc_edge) begin
        tty_active <= 1'b0;
        system_mode <= 1'b0;
      end else begin
        if (ex_tty) tty_active <= 1'b1;
        if (ev_sys) begin
          tty_active <= 1'b0;
          system_mode <= 1'b1;
        end
        if (state_q == ST_TTY && key_valid && key_func) begin
          tty_clear <= key_code == FKEY_CLEAR;
          if (key_code == FKEY_DUPLEX) tty_full <= !tty_full;
        end
      end
    end
  end

endmodule

//--- tb/lmc_monitor_properties.sv
`timescale 1ns/100ps
// ****
// Timing relations on the monitor's ports
// ****
module lmc_monitor_properties
  import lmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic key_valid,
  input wire logic key_func,
  input wire logic [7:0] key_code,
  input wire logic host_valid,
  input wire logic mem_ack,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [17:0] mem_addr,
  input wire logic mem_rom_sel,
  input wire logic refresh_start,
  input wire logic go_start,
  input wire logic opt_load,
  input wire logic tty_active,
  input wire logic tty_clear,
  input wire logic system_enter
);
  logic cr_key;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);

  // A plain return keystroke, the only trigger for executed commands
  assign cr_key = key_valid && !key_func && key_code == KEY_CR;

  a_req_holds: assert property (mem_req && !mem_ack |=> mem_req)
    else $error("memory request dropped before its ack");
  a_req_ends: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request still up after its ack");
  a_addr_steady: assert property (mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_we))
    else $error("memory address or direction moved while waiting");
  a_rom_window: assert property (mem_req && mem_rom_sel |-> mem_addr[17:15] == 3'h1)
    else $error("read-only select outside the bank zero upper half");
  a_refresh_on_cr: assert property (refresh_start |-> $past(cr_key))
    else $error("refresh started without a return key");
  a_go_on_cr: assert property (go_start |-> $past(cr_key))
    else $error("program start without a return key");
  a_opt_on_cr: assert property (opt_load |-> $past(cr_key))
    else $error("option load without a return key");
  a_sys_cause: assert property (system_enter |-> $past(key_valid || host_valid))
    else $error("system mode entered with no key or host code");
  a_clear_in_tty: assert property (tty_clear |-> $past(tty_active && key_valid && key_func))
    else $error("screen clear outside emulation");

  // Main scenarios reached
  c_write: cover property (mem_req && mem_ack && mem_we);
  c_system: cover property (system_enter);
  c_go: cover property (go_start);
endmodule

//--- tb/lmc_kbd_model.sv
`timescale 1ns/100ps
// ****
// Operator keyboard
// ****
module lmc_kbd_model (
  input wire logic clock,
  output logic key_valid,
  output logic key_func,
  output logic [7:0] key_code
);
  // Idle at time zero
  initial begin
    key_valid = 1'b0;
    key_func = 1'b0;
    key_code = 8'h00;
  end

  // One keystroke, one cycle wide; idle lines show the inverse so nothing stale
  // matches, and the gap keeps keys well apart
  task automatic hit(input logic fn, input logic [7:0] code);
    @(posedge clock);
    #1;
    key_valid = 1'b1;
    key_func = fn;
    key_code = code;
    @(posedge clock);
    #1;
    key_valid = 1'b0;
    key_func = ~fn;
    key_code = ~code;
    repeat (3) @(posedge clock);
  endtask
endmodule

//--- tb/test_local_monitor_command_interpreter.sv
`timescale 1ns/100ps
module test_local_monitor_command_interpreter
  import lmc_pkg::*;
;
  logic clock, srst, key_valid, key_func, host_valid, local_init, halt_exec, opts_end;
  logic mem_ack, mem_req, mem_we, mem_rom_sel, disp_stb, refresh_start, refresh_rom_sel;
  logic go_start, tape_load, opt_load, opt_unload, opt_status, tty_active, tty_clear;
  logic tty_full, system_mode, system_enter, rd_rom, dseen, busy;
  logic [17:0] mem_addr, disp_data, refresh_addr, rd_addr, wr_addr, ldata;
  logic [15:0] mem_rdata, mem_wdata, disp_addr, go_addr, halt_pc, laddr, wr_data;
  logic [7:0] key_code, host_code, seen;
  logic [11:0] opt_num;
  logic [2:0] disp_bank;
  lmc_disp_t disp_kind, lkind;
  int acnt, errors, cmp_count;

  lmc_monitor u_lmc_monitor (.*);
  lmc_kbd_model u_lmc_kbd_model (.*);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Memory answers two cycles into a request; data is junk outside the ack
  always @(posedge clock) begin
    #1;
    mem_ack = 1'b0;
    mem_rdata = ~mem_rdata;
    if (!mem_req) begin
      busy = 1'b0;
      acnt = 0;
    end else if (!busy && ++acnt == 2) begin
      busy = 1'b1;
      mem_ack = 1'b1;
      mem_rdata = mem_addr[15:0] ^ 16'h1357;
      if (mem_we) begin
        wr_addr = mem_addr;
        wr_data = mem_wdata;
      end else begin
        rd_addr = mem_addr;
        rd_rom = mem_rom_sel;
      end
    end
  end

  // Pulses and non-entry displays are latched, since keys take several cycles
  always @(posedge clock) begin
    seen <= seen | {refresh_start, go_start, tape_load, opt_load, opt_unload, opt_status,
      system_enter, tty_clear};
    if (disp_stb && disp_kind != DISP_ENTRY) begin
      dseen <= 1'b1;
      lkind <= disp_kind;
      laddr <= disp_addr;
      ldata <= disp_data;
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [17:0] word(input logic [15:0] a);
    return {2'b00, a ^ 16'h1357};
  endfunction

  task automatic k(input logic [7:0] c);
    u_lmc_kbd_model.hit(1'b0, c);
  endtask

  task automatic typ(input string s);
    for (int i = 0; i < s.len(); i++) begin
      k(s[i]);
    end
  endtask

  task automatic clr();
    #1;
    seen = 8'h00;
    dseen = 1'b0;
  endtask

  // Bounded wait for a display of one kind; running out ends the run
  task automatic wait_disp(input lmc_disp_t kd);
    int n;
    n = 0;
    while (!(dseen === 1'b1 && lkind === kd) && n < 60) begin
      @(posedge clock);
      #2;
      n++;
    end
    chk("display kind", 18'(kd), 18'(lkind));
    dseen = 1'b0;
    if (n >= 60) begin
      errors++;
      results();
    end
  endtask

  task automatic reinit();
    @(posedge clock);
    #1;
    local_init = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    local_init = 1'b0;
    wait_disp(DISP_PATTERN);
    chk("system mode", 18'h0, 18'(system_mode));
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
  endtask

  task automatic t_examine();
    typ("17");
    k(KEY_DEL);
    typ("00/");
    wait_disp(DISP_WORD);
    chk("addr", 18'h00040, 18'(laddr));
    chk("word", word(16'h0040), ldata);
    typ("/");
    wait_disp(DISP_WORD);
    chk("addr", 18'h00042, 18'(laddr));
    typ("^");
    wait_disp(DISP_WORD);
    chk("addr", 18'h00040, 18'(laddr));
    typ("55/");
    wait_disp(DISP_WORD);
    chk("wr addr", 18'h00040, wr_addr);
    chk("wr data", 18'h0002d, 18'(wr_data));
    chk("word", word(16'h0042), ldata);
    typ("7");
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
    chk("wr addr", 18'h00042, wr_addr);
    chk("wr data", 18'h00007, 18'(wr_data));
  endtask

  // Every bank code, upper half of the virtual range
  task automatic t_banks();
    for (int b = 0; b < 5; b++) begin
      k(KEY_B);
      k(KEY_D0 + 8'(b));
      typ("100002/");
      wait_disp(DISP_WORD);
      chk("bank", 18'(b), 18'(disp_bank));
      chk("phys", (b % 4 == 0) ? 18'h08002 : {b[1:0], 16'h8002}, rd_addr);
      chk("rom", 18'(b == 0), 18'(rd_rom));
      k(KEY_CR);
      wait_disp(DISP_PROMPT);
    end
    clr();
    typ("B7Z");
    chk("bank", 18'h4, 18'(disp_bank));
    chk("pulses", 18'h0, 18'(seen));
    typ("B0");
  endtask

  task automatic t_commands();
    clr();
    typ("20D");
    chk("pulses", 18'h0, 18'(seen));
    k(KEY_CR);
    chk("pulses", 18'h80, 18'(seen));
    chk("refresh addr", 18'h00010, refresh_addr);
    chk("refresh rom", 18'h0, 18'(refresh_rom_sel));
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
    clr();
    typ("L");
    k(KEY_CR);
    chk("pulses", 18'h20, 18'(seen));
    clr();
    typ("12L");
    k(KEY_CR);
    chk("pulses", 18'h10, 18'(seen));
    chk("option", 18'h0000a, 18'(opt_num));
    clr();
    typ("U");
    k(KEY_CR);
    chk("pulses", 18'h08, 18'(seen));
    clr();
    typ("O");
    k(KEY_CR);
    chk("pulses", 18'h04, 18'(seen));
    opts_end = 1'b1;
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
    @(posedge clock);
    #1;
    halt_exec = 1'b1;
    halt_pc = 16'h1234;
    @(posedge clock);
    #1;
    halt_exec = 1'b0;
    typ("Q");
    wait_disp(DISP_QADDR);
    chk("q value", 18'h01232, ldata);
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
    typ("Q");
    wait_disp(DISP_QADDR);
    chk("q value", 18'h01230, ldata);
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
  endtask

  task automatic t_modes();
    clr();
    typ("Y");
    k(KEY_CR);
    chk("tty", 18'h1, 18'(tty_active));
    u_lmc_kbd_model.hit(1'b1, 8'h00);
    chk("pulses", 18'h01, 18'(seen));
    u_lmc_kbd_model.hit(1'b1, 8'h01);
    chk("duplex", 18'h0, 18'(tty_full));
    @(posedge clock);
    #1;
    host_valid = 1'b1;
    host_code = 8'h1d;
    @(posedge clock);
    #1;
    host_valid = 1'b0;
    host_code = 8'he2;
    repeat (2) @(posedge clock);
    chk("system", 18'h1, 18'(system_mode));
    reinit();
    typ("Y");
    k(KEY_CR);
    clr();
    u_lmc_kbd_model.hit(1'b1, 8'h0d);
    chk("pulses", 18'h02, 18'(seen));
    reinit();
    clr();
    typ("S");
    chk("pulses", 18'h02, 18'(seen));
    reinit();
    typ("T");
    k(KEY_CR);
    wait_disp(DISP_PATTERN);
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
    clr();
    typ("400G");
    k(KEY_CR);
    chk("pulses", 18'h40, 18'(seen));
    chk("go addr", 18'h00100, 18'(go_addr));
  endtask

  // Reset for eight cycles, then the scenarios in turn
  initial begin
    srst = 1'b1;
    host_valid = 1'b0;
    host_code = 8'h00;
    local_init = 1'b0;
    halt_exec = 1'b0;
    halt_pc = 16'h0000;
    opts_end = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    busy = 1'b0;
    seen = 8'h00;
    dseen = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    srst = 1'b0;
    k(KEY_CR);
    wait_disp(DISP_PROMPT);
    chk("bank", 18'h0, 18'(disp_bank));
    t_examine();
    t_banks();
    t_commands();
    t_modes();
    results();
  end
endmodule

bind lmc_monitor lmc_monitor_properties u_lmc_monitor_properties (.clock, .srst, .key_valid,
  .key_func, .key_code, .host_valid, .mem_ack, .mem_req, .mem_we, .mem_addr, .mem_rom_sel,
  .refresh_start, .go_start, .opt_load, .tty_active, .tty_clear, .system_enter);
